// file: cbs_params.svh
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH
// ----------------------------------------
// link timing
// ----------------------------------------
`define CBS_CLK_PERIOD_NS 10
`define CBS_SCL_PERIOD_NS 2000
`define CBS_QTR_CYC       (`CBS_SCL_PERIOD_NS / (4 * `CBS_CLK_PERIOD_NS))
`define CBS_BUS_ADDR      7'h6D
`define CBS_BYTE_BITS     4'h8
// ----------------------------------------
// device register indices
// ----------------------------------------
`define CBS_REG_OE        3'h0
`define CBS_REG_MODE      3'h1
`define CBS_REG_RATE      3'h2
`define CBS_REG_FREQ      3'h3
`define CBS_REG_RSVD      3'h4
`define CBS_REG_REV       3'h5
`define CBS_REG_TYPE      3'h6
`define CBS_REG_COUNT     3'h7
`define CBS_REG_LAST      8'h07
// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define CBS_R0_RST        8'h2B
`define CBS_R1_RST        8'h06
`define CBS_R2_RST        8'hA9
`define CBS_R3_RST        8'h07
`define CBS_R4_RST        8'hFF
`define CBS_R7_RST        8'h08
`define CBS_WM0           8'h28
`define CBS_WM1           8'h3B
`define CBS_WM2           8'h28
`define CBS_WM3           8'h39
`define CBS_WM3_LOCKED    8'h21
`define CBS_WM7           8'h1F
// ----------------------------------------
// field positions
// ----------------------------------------
`define CBS_B_OUT1        5
`define CBS_B_OUT0        3
`define CBS_B_EN          5
`define CBS_F_HI          4
`define CBS_F_LO          3
`define CBS_B_FB          0
`define CBS_LATCH_HI      7
`define CBS_LATCH_LO      6
`define CBS_FREQ_DEFAULT  2'h0
// ----------------------------------------
// host controller registers
// ----------------------------------------
`define CBS_H_CTRL        8'h00
`define CBS_H_INDEX       8'h04
`define CBS_H_COUNT       8'h08
`define CBS_H_STATUS      8'h0C
`define CBS_H_DATA0       8'h10
`define CBS_H_DATA1       8'h14
`define CBS_CTRL_GO       0
`define CBS_CTRL_READ     1
`define CBS_MAX_BYTES     4'h8
`endif

// file: cbs_pkg.sv
package cbs_pkg;
  typedef enum logic [3:0] {
    D_IDLE, D_ADDR, D_INDEX, D_WCNT, D_WDATA, D_ACK, D_TX, D_RACK, D_WAIT
  } cbs_dst_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} cbs_mst_t;
  typedef enum logic [2:0] {
    S_ADDRW, S_INDEX, S_WCNT, S_WDATA, S_ADDRR, S_RCNT, S_RDATA
  } cbs_stg_t;
  typedef struct packed {
    logic [2:0]      scl;
    logic [2:0]      sda;
    logic [1:0][1:0] oen;
    logic [1:0][1:0] strap;
    logic [1:0]      lcnt;
    logic [1:0]      latched;
    cbs_dst_t        st;
    cbs_dst_t        ph;
    logic [3:0]      bc;
    logic [7:0]      sh;
    logic [7:0]      idx;
    logic [7:0]      rem;
    logic            rd;
    logic [7:0][7:0] rg;
    logic            sda_oe;
    logic [1:0]      out_en;
    logic [1:0]      pll_mode;
    logic [1:0]      amp;
    logic [1:0]      rate;
    logic            fb_rate;
    logic [1:0]      freq;
  } cbs_dev_t;
  typedef struct packed {
    logic [1:0]      sda;
    cbs_mst_t        st;
    cbs_stg_t        stg;
    logic [1:0]      qp;
    logic [7:0]      div;
    logic [3:0]      bc;
    logic [7:0]      sh;
    logic            rxm;
    logic            ack;
    logic [3:0]      bi;
    logic            scl_oe;
    logic            sda_oe;
    logic            rd;
    logic [7:0]      index;
    logic [3:0]      cnt;
    logic            busy;
    logic            nack;
    logic [7:0]      rxcnt;
    logic [7:0][7:0] buff;
    logic            av;
    logic            aw;
    logic [7:0]      aa;
    logic [31:0]     hrdata;
    logic            ready;
  } cbs_host_t;
endpackage

// file: cbs_if.sv
`timescale 1ns/100ps
interface cbs_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  // open-drain wires with pull-ups
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// file: cbs_device.sv
`timescale 1ns/100ps
`include "cbs_params.svh"
module cbs_device #(
  parameter logic [3:0] REV_CODE    = 4'h3,  // arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'h5,  // arbitrary value
  parameter logic [1:0] TYPE_CODE   = 2'h3,  // arbitrary value
  parameter logic [5:0] ID_CODE     = 6'h15  // arbitrary value
) (
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_I,
  cbs_if.dev              LINK,
  input  wire logic [1:0] PLL_MODE_STRAP_I,
  input  wire logic [1:0] OUT_OE_N_I,
  output logic      [1:0] OUT_EN_O,
  output logic      [1:0] PLL_MODE_O,
  output logic      [1:0] AMPLITUDE_O,
  output logic      [1:0] EDGE_RATE_O,
  output logic            FB_EDGE_RATE_O,
  output logic      [1:0] FREQ_CHOICE_O
);
  import cbs_pkg::*;

  cbs_dev_t q;
  cbs_dev_t d;

  // ----------------------------------------
  // register access helpers
  // ----------------------------------------
  // read view: out-of-map index reads zero, mode readback from strap latch
  function automatic logic [7:0] rd_byte(input logic [7:0] i, input cbs_dev_t s);
    logic [7:0] b;
    b = (i > `CBS_REG_LAST) ? 8'h00 : s.rg[i[2:0]];
    if (i[2:0] == `CBS_REG_MODE && i <= `CBS_REG_LAST) begin
      b[`CBS_LATCH_HI:`CBS_LATCH_LO] = s.latched;
    end
    return b;
  endfunction

  // writable bits per register; everything else keeps its current value
  function automatic logic [7:0] wmask(input logic [2:0] i, input logic en);
    logic [7:0] m;
    case (i)
      `CBS_REG_OE:    m = `CBS_WM0;
      `CBS_REG_MODE:  m = `CBS_WM1;
      `CBS_REG_RATE:  m = `CBS_WM2;
      `CBS_REG_FREQ:  m = en ? `CBS_WM3 : `CBS_WM3_LOCKED;
      `CBS_REG_COUNT: m = `CBS_WM7;
      default:        m = 8'h00;
    endcase
    return m;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       load;
    logic [7:0] tx;
    logic [7:0] m;
    rise  = q.scl[1] & ~q.scl[2];
    fall  = ~q.scl[1] & q.scl[2];
    start = q.scl[1] & q.scl[2] & q.sda[2] & ~q.sda[1];
    stop  = q.scl[1] & q.scl[2] & ~q.sda[2] & q.sda[1];
    load  = 1'b0;
    tx    = 8'h00;
    m     = 8'h00;
    d     = q;

    // two-flop synchronisers, third stage on scl and sda is the edge reference
    d.scl   = {q.scl[1:0], LINK.scl};
    d.sda   = {q.sda[1:0], LINK.sda};
    d.oen   = {q.oen[0], OUT_OE_N_I};
    d.strap = {q.strap[0], PLL_MODE_STRAP_I};

    // catch the mode strap once, after the synchroniser has filled
    if (q.lcnt != 2'h3) begin
      d.lcnt = q.lcnt + 2'h1;
      if (q.lcnt == 2'h2) begin
        d.latched = q.strap[1];
      end
    end

    // serial protocol engine
    if (start) begin
      d.st     = D_ADDR;
      d.bc     = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st     = D_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        D_ADDR, D_INDEX, D_WCNT, D_WDATA: begin
          if (rise && q.bc != `CBS_BYTE_BITS) begin
            d.sh = {q.sh[6:0], q.sda[1]};
            d.bc = q.bc + 4'h1;
          end else if (fall && q.bc == `CBS_BYTE_BITS) begin
            d.ph     = q.st;
            d.st     = D_ACK;
            d.sda_oe = 1'b1;
            case (q.st)
              D_ADDR: begin
                if (q.sh[7:1] != `CBS_BUS_ADDR) begin
                  d.st     = D_IDLE;
                  d.sda_oe = 1'b0;
                end else begin
                  d.rd = q.sh[0];
                end
              end
              D_INDEX: d.idx = q.sh;
              D_WCNT:  d.rem = q.sh;
              D_WDATA: begin
                if (q.rem != 8'h00) begin
                  if (q.idx <= `CBS_REG_LAST) begin
                    m = wmask(q.idx[2:0], q.sh[`CBS_B_EN]);
                    d.rg[q.idx[2:0]] = (q.sh & m) | (q.rg[q.idx[2:0]] & ~m);
                  end
                  d.idx = q.idx + 8'h01;
                  d.rem = q.rem - 8'h01;
                end
              end
              default: ;
            endcase
          end
        end
        D_ACK: begin
          if (fall) begin
            d.bc     = 4'h0;
            d.sda_oe = 1'b0;
            case (q.ph)
              D_ADDR: begin
                if (q.rd) begin
                  load = 1'b1;
                  tx   = rd_byte({5'h00, `CBS_REG_COUNT}, q);
                end else begin
                  d.st = D_INDEX;
                end
              end
              D_INDEX: d.st = D_WCNT;
              default: d.st = D_WDATA;
            endcase
          end
        end
        D_TX: begin
          if (fall) begin
            if (q.bc == `CBS_BYTE_BITS) begin
              d.sda_oe = 1'b0;
              d.st     = D_RACK;
            end else begin
              d.sda_oe = ~q.sh[7];
              d.sh     = {q.sh[6:0], 1'b0};
              d.bc     = q.bc + 4'h1;
            end
          end
        end
        D_RACK: begin
          if (rise && q.sda[1]) begin
            d.st = D_WAIT;
          end else if (fall) begin
            load  = 1'b1;
            tx    = rd_byte(q.idx, q);
            d.idx = q.idx + 8'h01;
          end
        end
        default: ;
      endcase
    end

    // start shifting a byte out: msb goes on the line at once
    if (load) begin
      d.st     = D_TX;
      d.sda_oe = ~tx[7];
      d.sh     = {tx[6:0], 1'b0};
      d.bc     = 4'h1;
    end

    // configuration outputs
    d.out_en   = {q.rg[`CBS_REG_OE][`CBS_B_OUT1] & ~q.oen[1][1],
                  q.rg[`CBS_REG_OE][`CBS_B_OUT0] & ~q.oen[1][0]};
    d.pll_mode = q.rg[`CBS_REG_MODE][`CBS_B_EN] ?
                 q.rg[`CBS_REG_MODE][`CBS_F_HI:`CBS_F_LO] : q.latched;
    d.amp      = q.rg[`CBS_REG_MODE][1:0];
    d.rate     = {q.rg[`CBS_REG_RATE][`CBS_B_OUT1],
                  q.rg[`CBS_REG_RATE][`CBS_B_OUT0]};
    d.fb_rate  = q.rg[`CBS_REG_FREQ][`CBS_B_FB];
    d.freq     = q.rg[`CBS_REG_FREQ][`CBS_B_EN] ?
                 q.rg[`CBS_REG_FREQ][`CBS_F_HI:`CBS_F_LO] : `CBS_FREQ_DEFAULT;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      q     <= '0;
      q.scl <= 3'h7;
      q.sda <= 3'h7;
      q.oen <= 4'hF;
      q.rg  <= {`CBS_R7_RST, TYPE_CODE, ID_CODE, REV_CODE, VENDOR_CODE, `CBS_R4_RST,
                `CBS_R3_RST, `CBS_R2_RST, `CBS_R1_RST, `CBS_R0_RST};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register, dev_sda_o tied low
  assign OUT_EN_O        = q.out_en;
  assign PLL_MODE_O      = q.pll_mode;
  assign AMPLITUDE_O     = q.amp;
  assign EDGE_RATE_O     = q.rate;
  assign FB_EDGE_RATE_O  = q.fb_rate;
  assign FREQ_CHOICE_O   = q.freq;
  assign LINK.dev_sda_oe = q.sda_oe;
  assign LINK.dev_sda_o  = 1'b0;
endmodule

// file: cbs_host.sv
`timescale 1ns/100ps
`include "cbs_params.svh"
module cbs_host (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  cbs_if.host              LINK,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O
);
  import cbs_pkg::*;

  cbs_host_t q;
  cbs_host_t d;

  // ----------------------------------------
  // register read view
  // ----------------------------------------
  function automatic logic [31:0] rd_word(input logic [7:0] a, input cbs_host_t s);
    case (a)
      `CBS_H_CTRL:   rd_word = {30'h0, s.rd, 1'b0};
      `CBS_H_INDEX:  rd_word = {24'h0, s.index};
      `CBS_H_COUNT:  rd_word = {28'h0, s.cnt};
      `CBS_H_STATUS: rd_word = {16'h0, s.rxcnt, 6'h0, s.nack, s.busy};
      `CBS_H_DATA0:  rd_word = s.buff[3:0];
      `CBS_H_DATA1:  rd_word = s.buff[7:4];
      default:       rd_word = 32'h0;
    endcase
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic tick;
    logic done;
    tick    = q.div == 8'(`CBS_QTR_CYC - 1);
    done    = 1'b0;
    d       = q;
    d.sda   = {q.sda[0], LINK.sda};
    d.ready = 1'b1;

    // bus slave: address phase captured, write applied in data phase
    d.av = HSEL_I & HREADY_I & HTRANS_I[1];
    if (d.av) begin
      d.aw = HWRITE_I;
      d.aa = HADDR_I[7:0];
      if (!HWRITE_I) begin
        d.hrdata = rd_word(HADDR_I[7:0], q);
      end
    end
    if (q.av && q.aw) begin
      case (q.aa)
        `CBS_H_CTRL: begin
          if (HWDATA_I[`CBS_CTRL_GO] && !q.busy) begin
            d.busy = 1'b1;
            d.nack = 1'b0;
            d.rd   = HWDATA_I[`CBS_CTRL_READ];
            d.st   = M_START;
            d.stg  = S_ADDRW;
          end
        end
        `CBS_H_INDEX: d.index = HWDATA_I[7:0];
        `CBS_H_COUNT: d.cnt = (HWDATA_I[3:0] > `CBS_MAX_BYTES) ? `CBS_MAX_BYTES : HWDATA_I[3:0];
        `CBS_H_DATA0: d.buff[3:0] = HWDATA_I;
        `CBS_H_DATA1: d.buff[7:4] = HWDATA_I;
        default: ;
      endcase
    end

    // quarter-bit divider makes the link clock
    if (q.st == M_IDLE) begin
      d.div = 8'h00;
      d.qp  = 2'h0;
    end else begin
      d.div = tick ? 8'h00 : q.div + 8'h01;
      d.qp  = tick ? q.qp + 2'h1 : q.qp;
    end

    if (tick) begin
      case (q.st)
        M_START: begin
          case (q.qp)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1;
            default: begin
              d.scl_oe = 1'b1;
              d.st     = M_BIT;
              d.bc     = 4'h0;
              d.rxm    = 1'b0;
              d.sh     = {`CBS_BUS_ADDR, q.stg == S_ADDRR};
            end
          endcase
        end
        M_BIT: begin
          case (q.qp)
            2'h0: d.sda_oe = (q.bc == `CBS_BYTE_BITS) ? (q.rxm & q.ack) : (~q.rxm & ~q.sh[7]);
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bc == `CBS_BYTE_BITS) begin
                if (!q.rxm) begin
                  d.ack = ~q.sda[1];
                end
              end else if (q.rxm) begin
                d.sh = {q.sh[6:0], q.sda[1]};
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              if (q.bc != `CBS_BYTE_BITS) begin
                d.bc = q.bc + 4'h1;
                if (!q.rxm) begin
                  d.sh = {q.sh[6:0], 1'b0};
                end
              end else begin
                d.bc = 4'h0;
                case (q.stg)
                  S_ADDRW: begin
                    d.stg = S_INDEX;
                    d.sh  = q.index;
                    done  = ~q.ack;
                    d.nack = ~q.ack;
                  end
                  S_INDEX: begin
                    if (q.rd) begin
                      d.st  = M_START;
                      d.stg = S_ADDRR;
                    end else begin
                      d.stg = S_WCNT;
                      d.sh  = {4'h0, q.cnt};
                    end
                  end
                  S_WCNT: begin
                    d.stg = S_WDATA;
                    d.bi  = 4'h0;
                    d.sh  = q.buff[0];
                    done  = q.cnt == 4'h0;
                  end
                  S_WDATA: begin
                    d.bi = q.bi + 4'h1;
                    d.sh = q.buff[3'(q.bi + 4'h1)];
                    done = (q.bi + 4'h1) == q.cnt;
                  end
                  S_ADDRR: begin
                    d.stg  = S_RCNT;
                    d.rxm  = 1'b1;
                    d.ack  = q.cnt != 4'h0;
                    done   = ~q.ack;
                    d.nack = ~q.ack;
                  end
                  S_RCNT: begin
                    d.rxcnt = q.sh;
                    d.stg   = S_RDATA;
                    d.bi    = 4'h0;
                    d.ack   = q.cnt > 4'h1;
                    done    = q.cnt == 4'h0;
                  end
                  default: begin
                    d.buff[q.bi[2:0]] = q.sh;
                    d.bi  = q.bi + 4'h1;
                    d.ack = (q.bi + 4'h2) < q.cnt;
                    done  = (q.bi + 4'h1) == q.cnt;
                  end
                endcase
              end
            end
          endcase
        end
        M_STOP: begin
          case (q.qp)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            default: begin
              d.st   = M_IDLE;
              d.busy = 1'b0;
            end
          endcase
        end
        default: ;
      endcase
    end
    if (done) begin
      d.st = M_STOP;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      q       <= '0;
      q.sda   <= 2'h3;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign HRDATA_O         = q.hrdata;
  assign HREADYOUT_O      = q.ready;
  assign HRESP_O          = 1'b0;
  assign LINK.host_scl_oe = q.scl_oe;
  assign LINK.host_scl_o  = 1'b0;
  assign LINK.host_sda_oe = q.sda_oe;
  assign LINK.host_sda_o  = 1'b0;
endmodule

// file: cbs_link_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// serial link checks
// ----------------------------------------
module cbs_link_asserts (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic [3:0] nb;     // bit slot within the byte
  logic [7:0] sh;     // bits seen at scl rise
  logic       first;  // first byte after a start
  logic       rw;     // direction of the transfer
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // follow slots, bytes and direction on the wire
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      nb    <= 4'h0;
      sh    <= 8'h00;
      first <= 1'b0;
      rw    <= 1'b0;
    end else if (scl && $fell(sda)) begin
      nb    <= 4'h0;
      first <= 1'b1;
    end else if ($rose(scl)) begin
      sh <= {sh[6:0], sda};
      nb <= (nb == 4'h8) ? 4'h0 : nb + 4'h1;
      if (nb == 4'h8) begin
        first <= 1'b0;
        rw    <= first ? sh[0] : rw;
      end
    end
  end
  a_open_drain: assert property (!host_scl_o && !host_sda_o && !dev_sda_o
    && (scl != host_scl_oe)) else $error("link pins not open drain");
  a_addr_ack_match: assert property ($rose(scl) && first && nb == 4'h8
    |-> dev_sda_oe == (sh[7:1] == 7'h6D)) else $error("address ack wrong");
  a_write_byte_ack: assert property ($rose(scl) && !first && nb == 4'h8 && !rw
    |-> dev_sda_oe [*8]) else $error("written byte not acked");
  a_read_ack_slot: assert property ($rose(scl) && !first && nb == 4'h8 && rw
    |-> !dev_sda_oe) else $error("device drives host ack slot");
  a_hold_scl_high: assert property (scl && $past(scl)
    |-> $stable(dev_sda_oe)) else $error("device data moved while scl high");
  a_stop_release: assert property (scl && $rose(sda)
    |=> !dev_sda_oe [*8]) else $error("device drives after stop");
  a_addr_quiet: assert property (first && nb < 4'h8
    |-> !dev_sda_oe) else $error("device drives during address");
  a_start_by_host: assert property (scl && $fell(sda)
    |-> host_sda_oe && !dev_sda_oe) else $error("start not made by host");
  c_start: cover property (scl && $fell(sda));
  c_write_ack: cover property ($rose(scl) && !first && nb == 4'h8 && !rw);
  c_read_ack: cover property ($rose(scl) && !first && nb == 4'h8 && rw);
  c_stop: cover property (scl && $rose(sda));
endmodule

// file: testbench.sv
`timescale 1ns/100ps
`include "cbs_params.svh"
module testbench;
  import cbs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [1:0]  strap = 2'h0;
  logic [1:0]  oe_n = 2'h0;
  logic [1:0]  out_en, pll_mode, amp, edge_rate, freq;
  logic        fb_rate;
  logic [31:0] rd, w;
  logic [31:0] w2;
  logic [7:0]  e3, x3;
  // identity codes handed to the device; the values are arbitrary
  localparam logic [7:0] REV_VEN = 8'h35;
  localparam logic [7:0] TYP_ID  = 8'hD5;
  int          err_total = 0;
  int          comparisons = 0;
  cbs_if link();
  cbs_device #(.REV_CODE(REV_VEN[7:4]), .VENDOR_CODE(REV_VEN[3:0]),
    .TYPE_CODE(TYP_ID[7:6]), .ID_CODE(TYP_ID[5:0])) i_cbs_device (.REF_CLK_I(clk),
    .RST_I(rst), .LINK(link),
    .PLL_MODE_STRAP_I(strap), .OUT_OE_N_I(oe_n), .OUT_EN_O(out_en),
    .PLL_MODE_O(pll_mode), .AMPLITUDE_O(amp), .EDGE_RATE_O(edge_rate),
    .FB_EDGE_RATE_O(fb_rate), .FREQ_CHOICE_O(freq));
  cbs_host i_cbs_host (.REF_CLK_I(clk), .RST_I(rst), .LINK(link), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp));
  cbs_link_asserts i_cbs_link_asserts (.REF_CLK_I(clk), .RST_I(rst), .scl(link.scl),
    .sda(link.sda), .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe));
  // clock at 100 MHz
  always #5 clk = ~clk;
  // verdict and end of run
  task automatic stop_test();
    $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bounded wait for hready
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      stop_test();
    end
  endtask
  // single word transfer on the register bus
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  // poll the busy flag with a bound
  task automatic wait_idle();
    logic [31:0] s;
    for (int k = 0; k < 60; k++) begin
      repeat (500) @(posedge clk);
      ahb(1'b0, `CBS_H_STATUS, 32'h0, s);
      if (s[0] === 1'b0) return;
    end
    err_total++;
    stop_test();
  endtask
  // expected readback of the mode and amplitude register
  function automatic logic [7:0] r1_exp(input logic [7:0] v, input logic [1:0] s);
    return (v & `CBS_WM1) | (`CBS_R1_RST & ~`CBS_WM1) | {s, 6'h00};
  endfunction
  // expected byte after a write: masked bits taken, the rest kept
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] v,
                                       input logic [7:0] m);
    return (v & m) | (old & ~m);
  endfunction
  // main sequence
  initial begin
    w     = $urandom(32'h55AA);
    strap = w[1:0];
    oe_n  = w[3:2];
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    check({30'h0, amp}, 32'h2);
    check({30'h0, edge_rate}, 32'h3);
    check({31'h0, fb_rate}, 32'h1);
    check({30'h0, freq}, 32'h0);
    check({30'h0, pll_mode}, {30'h0, strap});
    check({30'h0, out_en}, {30'h0, ~oe_n});
    ahb(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    w = $urandom;
    w[15:8] = w[15:8] | 8'h20;
    w[3] = 1'b0;
    ahb(1'b1, `CBS_H_INDEX, 32'h0, rd);
    ahb(1'b1, `CBS_H_COUNT, 32'h2, rd);
    ahb(1'b1, `CBS_H_DATA0, {16'h0, w[15:0]}, rd);
    ahb(1'b1, `CBS_H_CTRL, 32'h1, rd);
    wait_idle();
    ahb(1'b0, `CBS_H_STATUS, 32'h0, rd);
    check({31'h0, rd[1]}, 32'h0);
    check({30'h0, pll_mode}, {30'h0, w[12:11]});
    check({30'h0, amp}, {30'h0, w[9:8]});
    check({30'h0, out_en}, {30'h0, {w[5], w[3]} & ~oe_n});
    ahb(1'b1, `CBS_H_INDEX, 32'h1, rd);
    ahb(1'b1, `CBS_H_COUNT, 32'h1, rd);
    ahb(1'b1, `CBS_H_CTRL, 32'h3, rd);
    wait_idle();
    ahb(1'b0, `CBS_H_STATUS, 32'h0, rd);
    check({24'h0, rd[15:8]}, 32'h8);
    check({31'h0, rd[1]}, 32'h0);
    ahb(1'b0, `CBS_H_DATA0, 32'h0, rd);
    check({24'h0, rd[7:0]}, {24'h0, r1_exp(w[15:8], strap)});
    // block write of registers 2..7 with the frequency field unlocked
    w2 = $urandom;
    w  = $urandom;
    w2[13] = 1'b1;
    ahb(1'b1, `CBS_H_INDEX, 32'h2, rd);
    ahb(1'b1, `CBS_H_COUNT, 32'h6, rd);
    ahb(1'b1, `CBS_H_DATA0, w2, rd);
    ahb(1'b1, `CBS_H_DATA1, w, rd);
    ahb(1'b1, `CBS_H_CTRL, 32'h1, rd);
    wait_idle();
    check({30'h0, edge_rate}, {30'h0, w2[5], w2[3]});
    check({31'h0, fb_rate}, {31'h0, w2[8]});
    check({30'h0, freq}, {30'h0, w2[12:11]});
    // frequency field written with the unlock bit clear must not land
    e3 = ~w2[15:8] & 8'hDF;
    ahb(1'b1, `CBS_H_INDEX, 32'h3, rd);
    ahb(1'b1, `CBS_H_COUNT, 32'h1, rd);
    ahb(1'b1, `CBS_H_DATA0, {24'h0, e3}, rd);
    ahb(1'b1, `CBS_H_CTRL, 32'h1, rd);
    wait_idle();
    check({30'h0, freq}, 32'h0);
    // block read of registers 2..7
    ahb(1'b1, `CBS_H_INDEX, 32'h2, rd);
    ahb(1'b1, `CBS_H_COUNT, 32'h6, rd);
    ahb(1'b1, `CBS_H_CTRL, 32'h3, rd);
    wait_idle();
    ahb(1'b0, `CBS_H_STATUS, 32'h0, rd);
    check({24'h0, rd[15:8]}, {24'h0, merge(`CBS_R7_RST, w[15:8], `CBS_WM7)});
    ahb(1'b0, `CBS_H_DATA0, 32'h0, rd);
    x3 = merge(`CBS_R3_RST, w2[15:8], `CBS_WM3);
    check({24'h0, rd[7:0]}, {24'h0, merge(`CBS_R2_RST, w2[7:0], `CBS_WM2)});
    check({24'h0, rd[15:8]}, {24'h0, merge(x3, e3, `CBS_WM3_LOCKED)});
    check({24'h0, rd[23:16]}, {24'h0, `CBS_R4_RST});
    check({24'h0, rd[31:24]}, {24'h0, REV_VEN});
    ahb(1'b0, `CBS_H_DATA1, 32'h0, rd);
    check({24'h0, rd[7:0]}, {24'h0, TYP_ID});
    check({24'h0, rd[15:8]}, {24'h0, merge(`CBS_R7_RST, w[15:8], `CBS_WM7)});
    oe_n <= ~oe_n;
    repeat (8) @(posedge clk);
    check({30'h0, out_en}, {30'h0, {w[5], w[3]} & ~oe_n});
    stop_test();
  end
endmodule
